// [rtl/pmsd_regs.svh]
// Register offsets, field positions and timing constants of the mapping and display block
`ifndef PMSD_REGS_SVH
`define PMSD_REGS_SVH
`define PMSD_IDX_RX_ASSIGN 16'h1c12
`define PMSD_IDX_TX_ASSIGN 16'h1c13
`define PMSD_IDX_RX_MAP 16'h1600
`define PMSD_IDX_TX_MAP 16'h1a00
`define PMSD_IDX_RX_ALT_LO 16'h1701
`define PMSD_IDX_RX_ALT_HI 16'h1705
`define PMSD_IDX_TX_ALT_LO 16'h1b01
`define PMSD_IDX_TX_ALT_HI 16'h1b04
`define PMSD_ENT_IDX_HI 31
`define PMSD_ENT_IDX_LO 16
`define PMSD_ENT_SUB_HI 15
`define PMSD_ENT_SUB_LO 8
`define PMSD_ENT_LEN_HI 7
`define PMSD_ENT_LEN_LO 0
`define PMSD_LEN_8 8'h08
`define PMSD_LEN_16 8'h10
`define PMSD_LEN_32 8'h20
`define PMSD_MAX_ENTRIES 10
`define PMSD_BYTES_PER_ENTRY 4
`define PMSD_CLK_MHZ 200
`define PMSD_PREOP_HALF_MS 400
`define PMSD_SAFEOP_ON_MS 200
`define PMSD_SAFEOP_OFF_MS 1000
`define PMSD_RUN_HALF_MS 250
`define PMSD_MS_CYCLES (`PMSD_CLK_MHZ * 1000)
`endif

// [rtl/pmsd_pkg.sv]
// Types shared by the mapping and display block
`default_nettype none
package pmsd_pkg;
    typedef enum logic [3:0] {
        PMSD_NET_INIT = 4'h1,
        PMSD_NET_PREOP = 4'h2,
        PMSD_NET_SAFEOP = 4'h4,
        PMSD_NET_OP = 4'h8
    } pmsd_net_e;
    typedef enum logic [3:0] {
        PMSD_SRV_RESET = 4'h1,
        PMSD_SRV_NREADY = 4'h2,
        PMSD_SRV_READY = 4'h4,
        PMSD_SRV_RUN = 4'h8
    } pmsd_srv_e;
    typedef enum logic [7:0] {
        PMSD_ABORT_NONE = 8'h00,
        PMSD_ABORT_STATE = 8'h01,
        PMSD_ABORT_VALUE = 8'h02,
        PMSD_ABORT_OBJECT = 8'h03,
        PMSD_ABORT_SERVICE = 8'h04
    } pmsd_abort_e;
    typedef enum logic [1:0] {
        PMSD_SVC_REQUEST = 2'h0,
        PMSD_SVC_RESPONSE = 2'h1,
        PMSD_SVC_OTHER = 2'h2
    } pmsd_svc_e;
endpackage
`default_nettype wire

// [rtl/pmsd_blink.sv]
// Blink pattern generator for the network-state and status indicators
`timescale 1ns/10ps
`default_nettype none
`include "pmsd_regs.svh"
module pmsd_blink
    import pmsd_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `PMSD_MS_CYCLES
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pattern outputs
    output logic preop_on,
    output logic safeop_on,
    output logic run_on
);
    typedef struct packed {
        logic [17:0] tick;
        logic [10:0] ms;
        logic [8:0] ms_run;
        logic preop;
        logic run;
    } pmsd_blk_s;
    pmsd_blk_s st_r;
    pmsd_blk_s st_nxt;
    localparam logic [17:0] TICK_LAST = 18'(MS_CYCLES - 1);
    localparam int unsigned SAFE_PERIOD = `PMSD_SAFEOP_ON_MS + `PMSD_SAFEOP_OFF_MS;
    always_comb
    begin
        st_nxt = st_r;
        if (st_r.tick == TICK_LAST)
        begin
            st_nxt.tick = 18'h0;
            // One ms counter serves both slow patterns so they stay in phase
            if (st_r.ms == 11'(SAFE_PERIOD - 1))
            begin
                st_nxt.ms = 11'h0;
            end
            else
            begin
                st_nxt.ms = st_r.ms + 11'h1;
            end
            // Toggle on every 400 ms boundary, the period wrap included
            if (st_r.ms == 11'(`PMSD_PREOP_HALF_MS - 1)
                || st_r.ms == 11'(2 * `PMSD_PREOP_HALF_MS - 1)
                || st_r.ms == 11'(SAFE_PERIOD - 1))
            begin
                st_nxt.preop = ~st_r.preop;
            end
            if (st_r.ms_run == 9'(`PMSD_RUN_HALF_MS - 1))
            begin
                st_nxt.ms_run = 9'h0;
                st_nxt.run = ~st_r.run;
            end
            else
            begin
                st_nxt.ms_run = st_r.ms_run + 9'h1;
            end
        end
        else
        begin
            st_nxt.tick = st_r.tick + 18'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '{tick: 18'h0, ms: 11'h0, ms_run: 9'h0, preop: 1'b1, run: 1'b1};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign preop_on = st_r.preop;
    assign safeop_on = (st_r.ms < 11'(`PMSD_SAFEOP_ON_MS));
    assign run_on = st_r.run;
endmodule
`default_nettype wire

// [rtl/pmsd_top.sv]
// Process-data mapping store with request checks, and keypad status display drive
`timescale 1ns/10ps
`default_nettype none
`include "pmsd_regs.svh"
module pmsd_top
    import pmsd_pkg::*;
#(
    parameter int unsigned MAX_ENTRIES = `PMSD_MAX_ENTRIES,
    parameter int unsigned MS_CYCLES = `PMSD_MS_CYCLES
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mailbox write request from the network controller
    input wire logic sdo_req,
    input wire logic [1:0] sdo_svc,
    input wire logic [15:0] sdo_index,
    input wire logic [7:0] sdo_subindex,
    input wire logic [31:0] sdo_wdata,
    // Mailbox answer
    output logic sdo_ack,
    output logic sdo_abort,
    output logic [7:0] sdo_abort_code,
    output logic [31:0] sdo_rdata,
    // Drive state
    input wire logic [3:0] net_state,
    input wire logic [3:0] srv_state,
    input wire logic [7:0] op_mode,
    input wire logic motor_moving,
    input wire logic first_sync_pulse,
    input wire logic link_port_lower,
    input wire logic link_port_upper,
    // Mapping state seen by the cyclic exchange
    output logic rx_pdo_valid,
    output logic tx_pdo_valid,
    output logic [15:0] rx_assign,
    output logic [15:0] tx_assign,
    output logic [7:0] rx_bytes,
    output logic [7:0] tx_bytes,
    output logic sync_event,
    // Keypad
    output logic seg_link_upper,
    output logic seg_link_lower,
    output logic [7:0] disp_net,
    output logic [7:0] disp_mode,
    output logic [15:0] disp_status
);
    typedef struct packed {
        logic ack;
        logic abort;
        logic [7:0] code;
        logic [31:0] rdata;
        logic [1:0] valid;
        logic [15:0] rx_as;
        logic [15:0] tx_as;
        logic [3:0] rx_cnt;
        logic [3:0] tx_cnt;
        logic [MAX_ENTRIES*32-1:0] rx_map;
        logic [MAX_ENTRIES*32-1:0] tx_map;
        logic [2:0] up_s;
        logic [2:0] lo_s;
        logic [2:0] sy_s;
        logic up;
        logic lo;
        logic sy;
        logic sync;
        logic [7:0] d_net;
        logic [7:0] d_mode;
        logic [15:0] d_stat;
    } pmsd_st_s;
    pmsd_st_s st_r;
    pmsd_st_s st_nxt;
    logic preop_on;
    logic safeop_on;
    logic run_on;
    logic net_blink;
    logic is_rx_map;
    logic is_tx_map;
    logic is_rx_as;
    logic is_tx_as;
    logic is_map;
    logic len_ok;
    logic [3:0] sub_lo;
    // ********************************
    // Blink timing
    // ********************************
    pmsd_blink #(
        .MS_CYCLES(MS_CYCLES)
    ) u_blink (
        .clk(clk),
        .rst_n(rst_n),
        .preop_on(preop_on),
        .safeop_on(safeop_on),
        .run_on(run_on)
    );
    // ********************************
    // Request decode
    // ********************************
    assign is_rx_map = (sdo_index == `PMSD_IDX_RX_MAP);
    assign is_tx_map = (sdo_index == `PMSD_IDX_TX_MAP);
    assign is_rx_as = (sdo_index == `PMSD_IDX_RX_ASSIGN);
    assign is_tx_as = (sdo_index == `PMSD_IDX_TX_ASSIGN);
    assign is_map = is_rx_map | is_tx_map;
    assign sub_lo = sdo_subindex[3:0];
    assign len_ok = (sdo_wdata[`PMSD_ENT_LEN_HI:`PMSD_ENT_LEN_LO] == `PMSD_LEN_8)
        || (sdo_wdata[`PMSD_ENT_LEN_HI:`PMSD_ENT_LEN_LO] == `PMSD_LEN_16)
        || (sdo_wdata[`PMSD_ENT_LEN_HI:`PMSD_ENT_LEN_LO] == `PMSD_LEN_32);
    assign net_blink = (net_state == PMSD_NET_SAFEOP) ? safeop_on : preop_on;
    // ********************************
    // Next state
    // ********************************
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.abort = 1'b0;
        st_nxt.code = PMSD_ABORT_NONE;
        // Pin synchronisers; only stages 2 and 3 are compared
        st_nxt.up_s = {st_r.up_s[1:0], link_port_upper};
        st_nxt.lo_s = {st_r.lo_s[1:0], link_port_lower};
        st_nxt.sy_s = {st_r.sy_s[1:0], first_sync_pulse};
        if (st_r.up_s[1] == st_r.up_s[2])
        begin
            st_nxt.up = st_r.up_s[2];
        end
        if (st_r.lo_s[1] == st_r.lo_s[2])
        begin
            st_nxt.lo = st_r.lo_s[2];
        end
        if (st_r.sy_s[1] == st_r.sy_s[2])
        begin
            st_nxt.sy = st_r.sy_s[2];
        end
        // Edge taken from the held level, so a long pulse gives one event
        st_nxt.sync = (st_r.sy_s[1] == st_r.sy_s[2]) && st_r.sy_s[2] && !st_r.sy
            && (net_state != PMSD_NET_INIT);
        if (sdo_req)
        begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = 32'h0;
            if (sdo_svc != PMSD_SVC_REQUEST)
            begin
                st_nxt.abort = 1'b1;
                st_nxt.code = PMSD_ABORT_SERVICE;
            end
            else if (!(is_map || is_rx_as || is_tx_as))
            begin
                st_nxt.abort = 1'b1;
                st_nxt.code = PMSD_ABORT_OBJECT;
            end
            else if (net_state != PMSD_NET_PREOP)
            begin
                st_nxt.abort = 1'b1;
                st_nxt.code = PMSD_ABORT_STATE;
            end
            else if (is_rx_as || is_tx_as)
            begin
                if (sdo_subindex == 8'h00)
                begin
                    // Zero invalidates, one validates the object
                    if (sdo_wdata > 32'h1)
                    begin
                        st_nxt.abort = 1'b1;
                        st_nxt.code = PMSD_ABORT_VALUE;
                    end
                    else if (is_rx_as)
                    begin
                        st_nxt.valid[0] = sdo_wdata[0];
                    end
                    else
                    begin
                        st_nxt.valid[1] = sdo_wdata[0];
                    end
                end
                else if (sdo_subindex == 8'h01)
                begin
                    if (is_rx_as && (sdo_wdata[15:0] == `PMSD_IDX_RX_MAP
                        || (sdo_wdata[15:0] >= `PMSD_IDX_RX_ALT_LO
                        && sdo_wdata[15:0] <= `PMSD_IDX_RX_ALT_HI))
                        && sdo_wdata[31:16] == 16'h0)
                    begin
                        st_nxt.rx_as = sdo_wdata[15:0];
                    end
                    else if (is_tx_as && (sdo_wdata[15:0] == `PMSD_IDX_TX_MAP
                        || (sdo_wdata[15:0] >= `PMSD_IDX_TX_ALT_LO
                        && sdo_wdata[15:0] <= `PMSD_IDX_TX_ALT_HI))
                        && sdo_wdata[31:16] == 16'h0)
                    begin
                        st_nxt.tx_as = sdo_wdata[15:0];
                    end
                    else
                    begin
                        st_nxt.abort = 1'b1;
                        st_nxt.code = PMSD_ABORT_VALUE;
                    end
                end
                else
                begin
                    st_nxt.abort = 1'b1;
                    st_nxt.code = PMSD_ABORT_OBJECT;
                end
            end
            else if (sdo_subindex == 8'h00)
            begin
                if (sdo_wdata > 32'(MAX_ENTRIES))
                begin
                    st_nxt.abort = 1'b1;
                    st_nxt.code = PMSD_ABORT_VALUE;
                end
                else if (sdo_wdata == 32'h0)
                begin
                    // Clearing wipes the entries, not only the count
                    if (is_rx_map)
                    begin
                        st_nxt.rx_cnt = 4'h0;
                        st_nxt.rx_map = '0;
                    end
                    else
                    begin
                        st_nxt.tx_cnt = 4'h0;
                        st_nxt.tx_map = '0;
                    end
                end
                else if (is_rx_map)
                begin
                    st_nxt.rx_cnt = sdo_wdata[3:0];
                end
                else
                begin
                    st_nxt.tx_cnt = sdo_wdata[3:0];
                end
            end
            else if (sdo_subindex > 8'(MAX_ENTRIES))
            begin
                st_nxt.abort = 1'b1;
                st_nxt.code = PMSD_ABORT_OBJECT;
            end
            else if (!len_ok)
            begin
                st_nxt.abort = 1'b1;
                st_nxt.code = PMSD_ABORT_VALUE;
            end
            else if (is_rx_map)
            begin
                // Entry n is stored in slot n-1
                st_nxt.rx_map[(sub_lo - 4'h1)*32 +: 32] = sdo_wdata;
            end
            else
            begin
                st_nxt.tx_map[(sub_lo - 4'h1)*32 +: 32] = sdo_wdata;
            end
        end
        // ********************************
        // Keypad
        // ********************************
        case (net_state)
            PMSD_NET_INIT: st_nxt.d_net = 8'h01;
            PMSD_NET_PREOP: st_nxt.d_net = preop_on ? 8'h02 : 8'h00;
            PMSD_NET_SAFEOP: st_nxt.d_net = safeop_on ? 8'h04 : 8'h00;
            PMSD_NET_OP: st_nxt.d_net = 8'h08;
            default: st_nxt.d_net = 8'h00;
        endcase
        case (op_mode)
            8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09: st_nxt.d_mode = op_mode;
            8'h0a: st_nxt.d_mode = 8'h41;
            default: st_nxt.d_mode = 8'h2d;
        endcase
        // Status shown as two ASCII characters; a blank hides the second one
        case (srv_state)
            PMSD_SRV_RESET: st_nxt.d_stat = 16'h7273;
            PMSD_SRV_NREADY: st_nxt.d_stat = 16'h6e72;
            PMSD_SRV_READY: st_nxt.d_stat = 16'h7279;
            PMSD_SRV_RUN: st_nxt.d_stat = 16'h726e;
            default: st_nxt.d_stat = 16'h2d2d;
        endcase
        if (motor_moving && (srv_state == PMSD_SRV_READY || srv_state == PMSD_SRV_RUN))
        begin
            if ((net_state == PMSD_NET_PREOP || net_state == PMSD_NET_SAFEOP) ? !net_blink
                : !run_on)
            begin
                st_nxt.d_stat[7:0] = 8'h20;
            end
        end
    end
    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            // Power-up always returns to the default objects
            st_r.valid <= 2'h3;
            st_r.rx_as <= `PMSD_IDX_RX_MAP;
            st_r.tx_as <= `PMSD_IDX_TX_MAP;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign sdo_ack = st_r.ack;
    assign sdo_abort = st_r.abort;
    assign sdo_abort_code = st_r.code;
    assign sdo_rdata = st_r.rdata;
    assign rx_pdo_valid = st_r.valid[0];
    assign tx_pdo_valid = st_r.valid[1];
    assign rx_assign = st_r.rx_as;
    assign tx_assign = st_r.tx_as;
    assign rx_bytes = {2'h0, st_r.rx_cnt, 2'h0};
    assign tx_bytes = {2'h0, st_r.tx_cnt, 2'h0};
    assign sync_event = st_r.sync;
    assign seg_link_upper = st_r.up;
    assign seg_link_lower = st_r.lo;
    assign disp_net = st_r.d_net;
    assign disp_mode = st_r.d_mode;
    assign disp_status = st_r.d_stat;
endmodule
`default_nettype wire

// [tb/pmsd_top_properties.sv]
// Port checks of the mapping and display block
`timescale 1ns/10ps
`default_nettype none
module pmsd_top_properties
    import pmsd_pkg::*;
#(
    parameter int unsigned MAX_ENTRIES = 10
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mailbox
    input wire logic sdo_req,
    input wire logic [1:0] sdo_svc,
    input wire logic [15:0] sdo_index,
    input wire logic [7:0] sdo_subindex,
    input wire logic [31:0] sdo_wdata,
    input wire logic sdo_ack,
    input wire logic sdo_abort,
    input wire logic [7:0] sdo_abort_code,
    // Drive state
    input wire logic [3:0] net_state,
    input wire logic [7:0] op_mode,
    input wire logic link_port_lower,
    input wire logic link_port_upper,
    // Outputs
    input wire logic [15:0] rx_assign,
    input wire logic [7:0] rx_bytes,
    input wire logic [7:0] tx_bytes,
    input wire logic seg_link_upper,
    input wire logic seg_link_lower,
    input wire logic [7:0] disp_net,
    input wire logic [7:0] disp_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic ok_req;
    assign ok_req = sdo_req && sdo_svc == 2'h0 && net_state == 4'h2;
    ack_follows_a: assert property (sdo_req |=> sdo_ack)
        else $error("request without answer");
    service_only_a: assert property (sdo_req && sdo_svc != 2'h0 |=> sdo_abort && sdo_abort_code == 8'h04)
        else $error("foreign service not refused");
    preop_only_a: assert property (sdo_req && sdo_svc == 2'h0 && net_state != 4'h2
        && sdo_index inside {16'h1600, 16'h1a00, 16'h1c12, 16'h1c13}
        |=> sdo_abort && sdo_abort_code == 8'h01) else $error("write outside preop taken");
    refused_hold_a: assert property (sdo_abort |-> $stable(rx_bytes) && $stable(tx_bytes)
        && $stable(rx_assign)) else $error("refused write changed state");
    assign_range_a: assert property (ok_req && sdo_index == 16'h1c12 && sdo_subindex == 8'h01
        && !(sdo_wdata inside {32'h1600, [32'h1701:32'h1705]})
        |=> sdo_abort && sdo_abort_code == 8'h02) else $error("bad assignment taken");
    length_code_a: assert property (ok_req && sdo_index == 16'h1a00
        && sdo_subindex inside {[8'h01:8'h0a]} && !(sdo_wdata[7:0] inside {8'h08, 8'h10, 8'h20})
        |=> sdo_abort && sdo_abort_code == 8'h02) else $error("bad length taken");
    count_bytes_a: assert property (ok_req && sdo_index == 16'h1600 && sdo_subindex == 8'h00
        && sdo_wdata <= MAX_ENTRIES |=> !sdo_abort && rx_bytes == {$past(sdo_wdata[5:0]), 2'b00})
        else $error("byte length wrong");
    link_side_a: assert property ((link_port_upper && !link_port_lower)[*6]
        |-> seg_link_upper && !seg_link_lower) else $error("link segment swapped");
    net_glyph_a: assert property (($stable(net_state) && net_state inside {4'h1, 4'h8})[*3]
        |-> disp_net == {4'h0, net_state}) else $error("steady network glyph wrong");
    mode_glyph_a: assert property ($stable(op_mode)[*3] |-> disp_mode == (op_mode == 8'h0a ? 8'h41
        : (op_mode inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09} ? op_mode : 8'h2d)))
        else $error("mode glyph wrong");
endmodule
bind pmsd_top pmsd_top_properties #(.MAX_ENTRIES(MAX_ENTRIES)) u_props (.clk(clk), .rst_n(rst_n),
    .sdo_req(sdo_req), .sdo_svc(sdo_svc), .sdo_index(sdo_index), .sdo_subindex(sdo_subindex),
    .sdo_wdata(sdo_wdata), .sdo_ack(sdo_ack), .sdo_abort(sdo_abort),
    .sdo_abort_code(sdo_abort_code), .net_state(net_state), .op_mode(op_mode),
    .link_port_lower(link_port_lower), .link_port_upper(link_port_upper), .rx_assign(rx_assign),
    .rx_bytes(rx_bytes), .tx_bytes(tx_bytes), .seg_link_upper(seg_link_upper),
    .seg_link_lower(seg_link_lower), .disp_net(disp_net), .disp_mode(disp_mode));
`default_nettype wire

// [tb/pmsd_master_model.sv]
// Mailbox master issuing one write at a time
`timescale 1ns/10ps
`default_nettype none
module pmsd_master_model (
    // Clock
    input wire logic clk,
    // Request
    output logic sdo_req,
    output logic [1:0] sdo_svc,
    output logic [15:0] sdo_index,
    output logic [7:0] sdo_subindex,
    output logic [31:0] sdo_wdata,
    // Answer
    input wire logic sdo_ack,
    input wire logic sdo_abort,
    input wire logic [7:0] sdo_abort_code
);
    initial
    begin
        sdo_req = 1'b0;
        {sdo_svc, sdo_index, sdo_subindex, sdo_wdata} = '0;
    end
    // Fields are inverted once taken, so a late sample cannot pass on stale data
    task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
        input logic [1:0] svc, output logic [8:0] resp);
        int n;
        n = 0;
        resp = 9'h1ff;
        sdo_req = 1'b1;
        {sdo_svc, sdo_index, sdo_subindex, sdo_wdata} = {svc, idx, sub, d};
        @(posedge clk);
        #1;
        sdo_req = 1'b0;
        {sdo_svc, sdo_index, sdo_subindex, sdo_wdata} = ~{svc, idx, sub, d};
        while (sdo_ack !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (sdo_ack === 1'b1)
            resp = {sdo_abort, sdo_abort_code};
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// [tb/pmsd_top_tb.sv]
// Self-checking bench of the mapping and display block
`timescale 1ns/10ps
`default_nettype none
module pmsd_top_tb;
    import pmsd_pkg::*;
    // ****************************************
    // Bench state
    // ****************************************
    localparam int unsigned MS = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sdo_req, sdo_ack, sdo_abort, motor_moving, first_sync_pulse, sync_event;
    logic link_port_lower, link_port_upper, rx_pdo_valid, tx_pdo_valid;
    logic seg_link_upper, seg_link_lower;
    logic [1:0] sdo_svc;
    logic [3:0] net_state, srv_state;
    logic [7:0] sdo_subindex, sdo_abort_code, op_mode, rx_bytes, tx_bytes, disp_net, disp_mode;
    logic [15:0] sdo_index, rx_assign, tx_assign, disp_status, asg, map, alt;
    logic [31:0] sdo_wdata, sdo_rdata;
    logic [8:0] resp;
    logic [15:0] txt [4] = '{16'h7273, 16'h6e72, 16'h7279, 16'h726e};
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_sync = 0;
    int n, c;
    always #2.5 clk = ~clk;
    pmsd_top #(.MS_CYCLES(MS)) dut (.clk(clk), .rst_n(rst_n), .sdo_req(sdo_req),
        .sdo_svc(sdo_svc), .sdo_index(sdo_index), .sdo_subindex(sdo_subindex),
        .sdo_wdata(sdo_wdata), .sdo_ack(sdo_ack), .sdo_abort(sdo_abort),
        .sdo_abort_code(sdo_abort_code), .sdo_rdata(sdo_rdata), .net_state(net_state),
        .srv_state(srv_state), .op_mode(op_mode), .motor_moving(motor_moving),
        .first_sync_pulse(first_sync_pulse), .link_port_lower(link_port_lower),
        .link_port_upper(link_port_upper), .rx_pdo_valid(rx_pdo_valid),
        .tx_pdo_valid(tx_pdo_valid), .rx_assign(rx_assign), .tx_assign(tx_assign),
        .rx_bytes(rx_bytes), .tx_bytes(tx_bytes), .sync_event(sync_event),
        .seg_link_upper(seg_link_upper), .seg_link_lower(seg_link_lower),
        .disp_net(disp_net), .disp_mode(disp_mode), .disp_status(disp_status));
    pmsd_master_model m (.clk(clk), .sdo_req(sdo_req), .sdo_svc(sdo_svc),
        .sdo_index(sdo_index), .sdo_subindex(sdo_subindex), .sdo_wdata(sdo_wdata),
        .sdo_ack(sdo_ack), .sdo_abort(sdo_abort), .sdo_abort_code(sdo_abort_code));
    always @(posedge clk) n_sync <= n_sync + int'(sync_event === 1'b1);
    // Ceiling sits above the three long blink windows plus the mapping traffic
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] len_code(input int k);
        return k == 0 ? 8'h08 : (k == 1 ? 8'h10 : 8'h20);
    endfunction
    function automatic logic [7:0] mode_glyph(input logic [7:0] v);
        return v == 8'h0a ? 8'h41 : (v inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09} ? v : 8'h2d);
    endfunction
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
        input logic [7:0] code);
        logic [8:0] r;
        m.wr(idx, sub, d, 2'h0, r);
        chk({23'h0, r}, {23'h0, code != 8'h00, code});
    endtask
    task automatic defaults();
        step(2);
        chk({rx_assign, tx_assign}, 32'h16001a00);
        chk({rx_pdo_valid, tx_pdo_valid, rx_bytes, tx_bytes}, 32'h30000);
        chk(sdo_rdata, 32'h0);
    endtask
    task automatic pulse();
        // Held three cycles so the pin synchroniser stages can agree
        first_sync_pulse = 1'b1;
        step(3);
        first_sync_pulse = 1'b0;
        step(8);
    endtask
    task automatic count(input int len, input logic [15:0] pat, input logic st, output int hits);
        hits = 0;
        repeat (len)
        begin
            step(1);
            if ((st ? disp_status : {8'h00, disp_net}) === pat)
                hits++;
        end
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial
    begin
        net_state = 4'h1;
        srv_state = 4'h1;
        op_mode = 8'h00;
        motor_moving = 1'b0;
        first_sync_pulse = 1'b0;
        {link_port_upper, link_port_lower} = 2'b00;
        void'($urandom(32'h4de1));
        step(8);
        rst_n = 1'b1;
        defaults();
        xfer(16'h1600, 8'h00, 32'h0, 8'h01);
        pulse();
        chk(n_sync, 0);
        chk(disp_net, 8'h01);
        for (int k = 1; k < 4; k++)
        begin
            m.wr(16'h1600, 8'h00, 32'h0, 2'(k), resp);
            chk({23'h0, resp}, 32'h104);
        end
        for (int k = 0; k < 12; k++)
        begin
            op_mode = 8'(k);
            srv_state = 4'(1 << (k % 4));
            {link_port_upper, link_port_lower} = 2'(k);
            step(6);
            chk(disp_mode, mode_glyph(op_mode));
            chk(disp_status, txt[k % 4]);
            chk({seg_link_upper, seg_link_lower}, 32'(k % 4));
        end
        net_state = 4'h2;
        pulse();
        chk(n_sync, 1);
        for (int t = 0; t < 2; t++)
        begin
            asg = t ? 16'h1c13 : 16'h1c12;
            map = t ? 16'h1a00 : 16'h1600;
            alt = t ? 16'h1b01 + 16'($urandom_range(3)) : 16'h1701 + 16'($urandom_range(4));
            xfer(asg, 8'h00, 32'h0, 8'h00);
            chk(t ? tx_pdo_valid : rx_pdo_valid, 0);
            xfer(map, 8'h00, 32'h0, 8'h00);
            chk(t ? tx_bytes : rx_bytes, 0);
            for (int k = 1; k <= 10; k++)
                xfer(map, 8'(k), {24'($urandom), len_code($urandom_range(2))}, 8'h00);
            xfer(map, 8'h01, 32'h60400018, 8'h02);
            xfer(map, 8'h0b, 32'h60400010, 8'h03);
            xfer(map, 8'h00, 32'd11, 8'h02);
            xfer(map, 8'h00, 32'd10, 8'h00);
            chk(t ? tx_bytes : rx_bytes, 40);
            n = $urandom_range(10, 1);
            xfer(map, 8'h00, 32'(n), 8'h00);
            chk(t ? tx_bytes : rx_bytes, 4 * n);
            xfer(asg, 8'h01, t ? 32'h1b05 : 32'h1700, 8'h02);
            xfer(asg, 8'h01, {16'h0, map}, 8'h00);
            xfer(asg, 8'h01, {16'h0, alt}, 8'h00);
            chk(t ? tx_assign : rx_assign, alt);
            xfer(asg, 8'h00, 32'h1, 8'h00);
            chk(t ? tx_pdo_valid : rx_pdo_valid, 1);
        end
        xfer(16'h1234, 8'h00, 32'h0, 8'h03);
        net_state = 4'h4;
        xfer(16'h1a00, 8'h00, 32'h0, 8'h01);
        chk(tx_bytes, 4 * n);
        count(24000, 16'h0004, 1'b0, c);
        chk(c, 4000);
        net_state = 4'h2;
        count(16000, 16'h0002, 1'b0, c);
        chk(c, 8000);
        net_state = 4'h8;
        srv_state = 4'h8;
        motor_moving = 1'b1;
        count(10000, 16'h7220, 1'b1, c);
        chk(c, 5000);
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
        defaults();
        report_and_stop();
    end
endmodule
`default_nettype wire
